/* dss_regs.vh */
// Behaviour
// R1 - Host loads exactly 16,384 samples as the one waveform buffer.
// R2 - Samples pass the half-band interpolator with 26 update clocks latency.
// R3 - With the interpolator off the latency stays 26 update clocks.
// R4 - Converter updated at 80 MHz; memory reads advance at 40 MHz.
// R5 - 32-bit phase accumulator indexes memory; output samples are 12 bits.
// R6 - Lookup address wraps to the first location after the last.
// R7 - One frequency instruction loads a new increment; memory untouched.
// R8 - Each stage is a frequency instruction followed by a time instruction.
// R9 - Stage length comes only from its time instruction; no iteration count.
// R10 - Every stage plays the same lookup memory buffer.
// R11 - Host keeps each stage time at 2 us or more.
// R12 - Stage list holds up to 512 stages.
// R13 - Trigger source: software by default, external pin, or trigger bus line.
// R14 - Hardware triggers are taken on a rising edge.
// R15 - Single mode: one trigger runs all stages; last stage holds until stop.
// R16 - Continuous mode: one trigger, stages loop from last back to first.
// R17 - Stepped mode: each trigger advances one stage, wrapping cyclically.
// R18 - Stepped mode ignores stage times; only triggers pace stages.
// R19 - Stage changes keep accumulated phase; only the increment changes.
// R20 - Reset gives continuous mode, software trigger, interpolator enabled.
// R21 - Memory address is the top 14 bits of the accumulator.
// R22 - Software stop halts sequencing, returns to idle at stage one.
`ifndef DSS_REGS_VH
`define DSS_REGS_VH

// ----------------------------------------
// Modes and trigger sources
// ----------------------------------------
`define DSS_MODE_SINGLE 2'h0
`define DSS_MODE_CONT 2'h1
`define DSS_MODE_STEP 2'h2
`define DSS_SRC_SW 2'h0
`define DSS_SRC_EXT 2'h1
`define DSS_SRC_BUS 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSS_RST_MODE `DSS_MODE_CONT
`define DSS_RST_SRC `DSS_SRC_SW
`define DSS_RST_FILT 1'b1

// ----------------------------------------
// Instruction word layout
// ----------------------------------------
`define DSS_INSTR_W 33
`define DSS_INSTR_TYPE_BIT 32
`define DSS_ACC_ADDR_LSB 18

// ----------------------------------------
// Timing
// ----------------------------------------
`define DSS_UPD_HZ 40000000
`define DSS_DAC_HZ 80000000
`define DSS_DAC_PER_UPD (`DSS_DAC_HZ / `DSS_UPD_HZ)
`define DSS_HBF_LAT_UPD 26
`define DSS_HBF_LAT_CYC (`DSS_HBF_LAT_UPD * `DSS_DAC_PER_UPD)
`define DSS_MIN_STAGE_NS 2000
`define DSS_MIN_STAGE_UPD ((`DSS_MIN_STAGE_NS * (`DSS_UPD_HZ / 1000000) + 999) / 1000)

`endif

/* dss_fifo.v */
`timescale 1ns/100ps
module dss_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_in_vld,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_in_rdy,
  output reg o_out_vld,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_rdy
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] cnt_r;
  reg [AW:0] cnt_nxt;
  wire push;
  wire pop;

  assign push = i_in_vld & o_in_rdy;
  assign pop = o_out_vld & i_out_rdy;
  assign o_out_data = mem[rptr_r];

  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Flags registered so both ready and valid leave straight from flops
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      o_in_rdy <= 1'b1;
      o_out_vld <= 1'b0;
    end else begin
      if (push) begin
        mem[wptr_r] <= i_in_data;
        wptr_r <= (wptr_r == DEPTH - 1) ? {AW{1'b0}} : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == DEPTH - 1) ? {AW{1'b0}} : rptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      o_in_rdy <= (cnt_nxt != DEPTH);
      o_out_vld <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end
endmodule // dss_fifo

/* dss_hbf.v */
`timescale 1ns/100ps
module dss_hbf #(
  parameter DW = 12,
  parameter LAT = 52
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_filt_en,
  input wire i_smp_vld,
  input wire [DW-1:0] i_smp,
  output wire [DW-1:0] o_dac
);
  // Core takes 2 cycles; padding makes up the rest either way
  localparam PAD = LAT - 2;
  reg [DW-1:0] s1_r;
  reg [DW-1:0] mid_r;
  reg [DW-1:0] y_r;
  reg [DW-1:0] pad_r [0:PAD-1];
  wire [DW:0] sum;

  assign sum = {s1_r[DW-1], s1_r} + {i_smp[DW-1], i_smp};
  assign o_dac = pad_r[PAD-1];

  // Odd slots: midpoint when filtering, repeat when not
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      s1_r <= {DW{1'b0}};
      mid_r <= {DW{1'b0}};
      y_r <= {DW{1'b0}};
    end else if (i_smp_vld) begin
      y_r <= s1_r; // R4
      s1_r <= i_smp;
      mid_r <= i_filt_en ? sum[DW:1] : s1_r; // R2 R3
    end else begin
      y_r <= mid_r; // R4
    end
  end

  genvar g;
  generate
    for (g = 0; g < PAD; g = g + 1) begin : g_pad
      // Head and tail split so no stage ever names an index below zero
      if (g == 0) begin : g_head
        always @(posedge i_clk_sys) begin
          if (!i_rst_b) begin
            pad_r[0] <= {DW{1'b0}};
          end else begin
            pad_r[0] <= y_r; // R2 R3
          end
        end
      end else begin : g_tail
        always @(posedge i_clk_sys) begin
          if (!i_rst_b) begin
            pad_r[g] <= {DW{1'b0}};
          end else begin
            pad_r[g] <= pad_r[g-1]; // R2 R3
          end
        end
      end
    end
  endgenerate
endmodule // dss_hbf

/* dss_seq.v */
`timescale 1ns/100ps
`include "dss_regs.vh"
module dss_seq #(
  parameter MEM_DEPTH = 16384,
  parameter MEM_AW = 14,
  parameter DW = 12,
  parameter STAGES = 512,
  parameter SAW = 9,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5,
  parameter TRIG_LINES = 8,
  parameter TLW = 3
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_mem_wr,
  input wire [MEM_AW-1:0] i_mem_addr,
  input wire [DW-1:0] i_mem_data,
  input wire i_instr_vld,
  input wire [`DSS_INSTR_W-1:0] i_instr_data,
  output wire o_instr_rdy,
  input wire i_list_clear,
  input wire i_cfg_wr,
  input wire [1:0] i_cfg_mode,
  input wire [1:0] i_cfg_src,
  input wire [TLW-1:0] i_cfg_line,
  input wire i_cfg_filt_en,
  input wire i_sw_trig,
  input wire i_sw_stop,
  input wire i_ext_trig,
  input wire [TRIG_LINES-1:0] i_trig_bus,
  output reg [DW-1:0] o_dac_data,
  output reg o_running,
  output reg [SAW-1:0] o_stage_idx,
  output reg [SAW:0] o_list_count,
  output reg o_list_full,
  output reg [1:0] o_mode,
  output reg [1:0] o_src,
  output reg o_filt_en
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_HOLD = 2'h2;
  localparam ST_STEP = 2'h3;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [DW-1:0] wave_mem [0:MEM_DEPTH-1];
  reg [31:0] stg_freq [0:STAGES-1];
  reg [31:0] stg_time [0:STAGES-1];

  reg [1:0] state_r;
  reg [1:0] run_mode_r;
  reg [TLW-1:0] line_r;
  reg [31:0] pend_freq_r;
  reg [31:0] acc_r;
  reg [31:0] incr_r;
  reg [31:0] timer_r;
  reg upd_r;
  reg smp_vld_r;
  reg [DW-1:0] smp_r;
  reg ext_prev_r;
  reg [TRIG_LINES-1:0] bus_prev_r;
  reg trig;
  reg [SAW-1:0] next_idx;
  reg last_stage;

  wire f_vld;
  wire [`DSS_INSTR_W-1:0] f_data;
  wire f_rdy;
  wire [DW-1:0] hbf_dac;
  wire [MEM_AW-1:0] rd_addr;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Zero time would wrap the down-counter to a full 32-bit count; treat as one update clock
  function [31:0] stage_len;
    input [31:0] t;
    begin
      stage_len = (t == 32'h0000_0000) ? 32'h0000_0001 : t;
    end
  endfunction

  // ----------------------------------------
  // Instruction intake
  // ----------------------------------------
  // List only fills while idle, so the FIFO backs up during generation
  assign f_rdy = (state_r == ST_IDLE) & ~o_list_full & ~i_list_clear;

  dss_fifo #(
    .WIDTH(`DSS_INSTR_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_in_vld(i_instr_vld),
    .i_in_data(i_instr_data),
    .o_in_rdy(o_instr_rdy),
    .o_out_vld(f_vld),
    .o_out_data(f_data),
    .i_out_rdy(f_rdy)
  );

  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pend_freq_r <= 32'h0000_0000;
      o_list_count <= {(SAW+1){1'b0}};
      o_list_full <= 1'b0;
    end else if (i_list_clear && state_r == ST_IDLE) begin
      o_list_count <= {(SAW+1){1'b0}};
      o_list_full <= 1'b0;
    end else if (f_vld && f_rdy) begin
      if (!f_data[`DSS_INSTR_TYPE_BIT]) begin
        pend_freq_r <= f_data[31:0]; // R8
      end else begin
        stg_freq[o_list_count[SAW-1:0]] <= pend_freq_r; // R8
        stg_time[o_list_count[SAW-1:0]] <= f_data[31:0]; // R8 R9
        o_list_count <= o_list_count + 1'b1;
        o_list_full <= (o_list_count == STAGES - 1); // R12
      end
    end
  end

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_mode <= `DSS_RST_MODE; // R20
      o_src <= `DSS_RST_SRC; // R20
      o_filt_en <= `DSS_RST_FILT; // R20
      line_r <= {TLW{1'b0}};
    end else if (i_cfg_wr) begin
      o_mode <= (i_cfg_mode == 2'h3) ? `DSS_MODE_CONT : i_cfg_mode;
      o_src <= (i_cfg_src == 2'h3) ? `DSS_SRC_SW : i_cfg_src; // R13
      o_filt_en <= i_cfg_filt_en;
      line_r <= i_cfg_line;
    end
  end

  // ----------------------------------------
  // Trigger selection
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ext_prev_r <= 1'b0;
      bus_prev_r <= {TRIG_LINES{1'b0}};
    end else begin
      ext_prev_r <= i_ext_trig;
      bus_prev_r <= i_trig_bus;
    end
  end

  always @* begin
    if (o_src == `DSS_SRC_EXT) begin
      trig = i_ext_trig & ~ext_prev_r; // R13 R14
    end else if (o_src == `DSS_SRC_BUS) begin
      trig = i_trig_bus[line_r] & ~bus_prev_r[line_r]; // R13 R14
    end else begin
      trig = i_sw_trig; // R13
    end
  end

  // ----------------------------------------
  // Stage sequencer
  // ----------------------------------------
  always @* begin
    last_stage = ({1'b0, o_stage_idx} == o_list_count - 1'b1);
    next_idx = last_stage ? {SAW{1'b0}} : o_stage_idx + 1'b1; // R16 R17
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      run_mode_r <= `DSS_RST_MODE;
      o_stage_idx <= {SAW{1'b0}};
      o_running <= 1'b0;
      incr_r <= 32'h0000_0000;
      timer_r <= 32'h0000_0000;
    end else if (i_sw_stop) begin
      state_r <= ST_IDLE; // R22
      o_stage_idx <= {SAW{1'b0}}; // R22
      o_running <= 1'b0;
      incr_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (trig && o_list_count != {(SAW+1){1'b0}}) begin
            run_mode_r <= o_mode;
            o_stage_idx <= {SAW{1'b0}}; // R15 R16 R17
            o_running <= 1'b1;
            incr_r <= stg_freq[0]; // R7
            timer_r <= stage_len(stg_time[0]); // R9
            state_r <= (o_mode == `DSS_MODE_STEP) ? ST_STEP : ST_RUN; // R18
          end
        end
        ST_RUN: begin
          if (upd_r) begin
            if (timer_r == 32'h0000_0001) begin
              if (last_stage && run_mode_r == `DSS_MODE_SINGLE) begin
                state_r <= ST_HOLD; // R15
              end else begin
                o_stage_idx <= next_idx; // R16
                incr_r <= stg_freq[next_idx]; // R19
                timer_r <= stage_len(stg_time[next_idx]); // R9
              end
            end else begin
              timer_r <= timer_r - 1'b1; // R9
            end
          end
        end
        ST_HOLD: begin
          state_r <= ST_HOLD; // R15
        end
        ST_STEP: begin
          if (trig) begin
            o_stage_idx <= next_idx; // R17
            incr_r <= stg_freq[next_idx]; // R18 R19
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Phase accumulator and lookup
  // ----------------------------------------
  // Accumulator is never cleared between stages, keeping phase continuous
  assign rd_addr = acc_r[31:`DSS_ACC_ADDR_LSB]; // R5 R21

  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      upd_r <= 1'b0;
      acc_r <= 32'h0000_0000;
      smp_vld_r <= 1'b0;
      smp_r <= {DW{1'b0}};
    end else begin
      upd_r <= ~upd_r; // R4
      smp_vld_r <= upd_r;
      if (upd_r) begin
        acc_r <= acc_r + incr_r; // R5 R6 R19
        smp_r <= wave_mem[rd_addr]; // R6 R10
      end
    end
  end

  // Host write port; buffer must hold exactly one full cycle
  always @(posedge i_clk_sys) begin
    if (i_mem_wr) begin
      wave_mem[i_mem_addr] <= i_mem_data; // R1
    end
  end

  // ----------------------------------------
  // Interpolator and converter stream
  // ----------------------------------------
  dss_hbf #(
    .DW(DW),
    .LAT(`DSS_HBF_LAT_CYC)
  ) u_hbf (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_filt_en(o_filt_en),
    .i_smp_vld(smp_vld_r),
    .i_smp(smp_r),
    .o_dac(hbf_dac)
  );

  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_dac_data <= {DW{1'b0}};
    end else begin
      o_dac_data <= hbf_dac; // R2 R4
    end
  end
endmodule // dss_seq

/* dss_seq_chk.sv */
`timescale 1ns/100ps
module dss_seq_chk #(
  parameter STAGES = 512,
  parameter SAW = 9
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_cfg_wr,
  input wire [1:0] i_cfg_src,
  input wire i_sw_trig,
  input wire i_sw_stop,
  input wire i_ext_trig,
  input wire o_running,
  input wire [SAW-1:0] o_stage_idx,
  input wire [SAW:0] o_list_count,
  input wire [1:0] o_mode,
  input wire [1:0] o_src,
  input wire o_filt_en
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire [SAW:0] idx_inc = {1'h0, o_stage_idx} + 1'h1;
  wire [SAW-1:0] idx_wrap = (idx_inc == o_list_count) ? {SAW{1'h0}} : idx_inc[SAW-1:0];
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_ready;
    !o_running && o_list_count != 0 && !i_sw_stop;
  endsequence
  sequence s_idle;
    !o_running && o_stage_idx == 0;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_rst_defaults: assert property (disable iff (1'h0)
    !i_rst_b |=> o_mode == 2'h1 && o_src == 2'h0 && o_filt_en && !o_running)
    else $error("reset defaults wrong");
  a_sw_start: assert property (s_ready ##0 (o_src == 2'h0 && i_sw_trig) |=> o_running)
    else $error("software start missed");
  a_ext_rise: assert property (s_ready ##0 (o_src == 2'h1 && $rose(i_ext_trig))
    |=> o_running && o_stage_idx == 0)
    else $error("external edge start missed");
  a_stop_idle: assert property (i_sw_stop |=> s_idle)
    else $error("stop did not idle");
  a_cfg_src: assert property (i_cfg_wr |=>
    o_src == (($past(i_cfg_src) == 2'h3) ? 2'h0 : $past(i_cfg_src)))
    else $error("source select wrong");
  a_idx_range: assert property (o_running |-> o_stage_idx < o_list_count)
    else $error("stage index out of list");
  a_step_next: assert property (o_running && o_mode == 2'h2 && o_src == 2'h0 && i_sw_trig
    && !i_sw_stop |=> o_stage_idx == $past(idx_wrap))
    else $error("step advance wrong");
  a_step_hold: assert property (o_running && o_mode == 2'h2 && o_src == 2'h0 && !i_sw_trig
    && !i_sw_stop |=> $stable(o_stage_idx) && o_running)
    else $error("step moved without trigger");
  a_single_last: assert property (o_running && o_mode == 2'h0 && !i_sw_stop
    && o_stage_idx == o_list_count - 1'h1 |=> o_running && $stable(o_stage_idx))
    else $error("single mode left last stage");
  a_list_bound: assert property (o_list_count <= STAGES)
    else $error("list count above capacity");
endmodule // dss_seq_chk

/* dss_host.sv */
`timescale 1ns/100ps
module dss_host (
  input wire i_clk_sys,
  output reg o_mem_wr,
  output reg [13:0] o_mem_addr,
  output reg [11:0] o_mem_data,
  output reg o_instr_vld,
  output reg [32:0] o_instr_data,
  input wire i_instr_rdy
);
  integer k;
  initial begin
    o_mem_wr = 1'h0;
    o_mem_addr = 14'h0;
    o_mem_data = 12'h0;
    o_instr_vld = 1'h0;
    o_instr_data = 33'h0;
  end
  // ----------------------------------------
  // One whole buffer, low half then high half
  // ----------------------------------------
  task fill_mem;
    begin
      for (k = 0; k < 16384; k = k + 1) begin
        @(posedge i_clk_sys);
        o_mem_wr <= 1'h1;
        o_mem_addr <= k[13:0];
        o_mem_data <= k[13] ? 12'h200 : 12'h100;
      end
      @(posedge i_clk_sys);
      o_mem_wr <= 1'h0;
      o_mem_data <= 12'hAAA;
    end
  endtask
  // Word held until taken; bounded so a full list cannot hang us
  task push(input [32:0] w, output ok);
    integer n;
    begin
      @(posedge i_clk_sys);
      o_instr_vld <= 1'h1;
      o_instr_data <= w;
      ok = 1'h0;
      for (n = 0; n < 40 && !ok; n = n + 1) begin
        @(posedge i_clk_sys);
        ok = i_instr_rdy;
      end
      o_instr_vld <= 1'h0;
      o_instr_data <= ~w;
    end
  endtask
  // Caller keeps times at 80 update clocks or more
  task push_stage(input [31:0] f, input [31:0] t, output ok);
    reg a;
    begin
      push({1'h0, f}, a);
      push({1'h1, t}, ok);
      ok = ok & a;
    end
  endtask
endmodule // dss_host

/* dss_seq_tb.sv */
`timescale 1ns/100ps
module dss_seq_tb;
  reg i_clk_sys, i_rst_b, i_cfg_filt_en, i_ext_trig, ok;
  reg [3:0] pl;
  reg [1:0] i_cfg_mode, i_cfg_src;
  reg [2:0] i_cfg_line;
  reg [7:0] i_trig_bus;
  reg [11:0] prev;
  wire mem_wr, instr_vld, o_instr_rdy, o_running, o_list_full, o_filt_en;
  wire [13:0] mem_addr;
  wire [11:0] mem_data, o_dac_data;
  wire [32:0] instr_data;
  wire [8:0] o_stage_idx;
  wire [9:0] o_list_count;
  wire [1:0] o_mode, o_src;
  integer fail_count, samples_checked, n, k;
  dss_seq uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_mem_wr(mem_wr),
    .i_mem_addr(mem_addr), .i_mem_data(mem_data), .i_instr_vld(instr_vld),
    .i_instr_data(instr_data), .o_instr_rdy(o_instr_rdy), .i_list_clear(pl[2]),
    .i_cfg_wr(pl[3]), .i_cfg_mode(i_cfg_mode), .i_cfg_src(i_cfg_src), .i_cfg_line(i_cfg_line),
    .i_cfg_filt_en(i_cfg_filt_en), .i_sw_trig(pl[0]), .i_sw_stop(pl[1]),
    .i_ext_trig(i_ext_trig), .i_trig_bus(i_trig_bus), .o_dac_data(o_dac_data),
    .o_running(o_running), .o_stage_idx(o_stage_idx), .o_list_count(o_list_count),
    .o_list_full(o_list_full), .o_mode(o_mode), .o_src(o_src), .o_filt_en(o_filt_en));
  dss_host host (.i_clk_sys(i_clk_sys), .o_mem_wr(mem_wr), .o_mem_addr(mem_addr),
    .o_mem_data(mem_data), .o_instr_vld(instr_vld), .o_instr_data(instr_data),
    .i_instr_rdy(o_instr_rdy));
  initial begin
    i_clk_sys = 1'h0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task stop_test;
    begin
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input string msg);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t %s", $time, msg);
      end
    end
  endtask
  task chk_rng(input integer got, input integer lo, input integer hi, input string msg);
    chk(got >= lo && got <= hi, 1, msg);
  endtask
  task pulse(input [3:0] m);
    begin
      @(posedge i_clk_sys);
      pl <= m;
      @(posedge i_clk_sys);
      pl <= 4'h0;
      @(posedge i_clk_sys);
    end
  endtask
  task cfg(input [1:0] m, input [1:0] s, input f);
    begin
      i_cfg_mode <= m;
      i_cfg_src <= s;
      i_cfg_filt_en <= f;
      pulse(4'h8);
    end
  endtask
  // Bounded wait; n ends as the cycles waited
  task wait_idx(input [8:0] t, input integer bound);
    begin
      for (n = 0; o_stage_idx !== t && n < bound; n = n + 1) @(posedge i_clk_sys);
      if (n == bound) begin
        chk(0, 1, "stage wait timed out");
        stop_test;
      end
    end
  endtask
  // A refused stage would silently shorten the list
  task stage(input [31:0] f);
    begin
      host.push_stage(f, 80, ok);
      chk(ok, 1, "stage push refused");
      if (!ok) begin
        stop_test;
      end
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_cont;
    begin
      for (k = 0; k < 3; k = k + 1) stage(k[0] ? 32'h0 : 32'h8000_0000);
      repeat (5) @(posedge i_clk_sys);
      chk(o_list_count, 3, "stage count");
      // Mode code 3 falls back to continuous
      cfg(2'h3, 2'h1, 1'h0);
      chk({o_mode, o_src, o_filt_en}, 5'h0A, "mode 3 config");
      repeat (80) @(posedge i_clk_sys);
      i_ext_trig <= 1'h1;
      for (n = 0; o_dac_data === 12'h100 && n < 100; n = n + 1) @(posedge i_clk_sys);
      chk_rng(n, 52, 66, "latency filter off");
      prev = o_dac_data;
      k = 0;
      repeat (8) begin
        @(posedge i_clk_sys);
        k = k + (o_dac_data !== prev);
        prev = o_dac_data;
        chk(prev == 12'h100 || prev == 12'h200, 1, "wrapped sample value");
      end
      chk(k, 4, "converter slot rate");
      wait_idx(1, 400);
      wait_idx(2, 400);
      chk_rng(n, 158, 162, "stage length");
      wait_idx(0, 400);
      i_ext_trig <= 1'h0;
      pulse(4'h2);
      chk(o_running, 0, "stop running");
      chk(o_stage_idx, 0, "stop index");
    end
  endtask
  task t_single;
    begin
      i_cfg_line <= 3'h5;
      cfg(2'h0, 2'h2, 1'h1);
      i_trig_bus <= 8'h08;
      repeat (3) @(posedge i_clk_sys);
      chk(o_running, 0, "unselected bus line");
      i_trig_bus <= 8'h28;
      wait_idx(2, 800);
      for (n = 0; o_dac_data !== 12'h180 && n < 100; n = n + 1) @(posedge i_clk_sys);
      chk(o_dac_data, 12'h180, "interpolated slot");
      repeat (400) @(posedge i_clk_sys);
      chk({o_running, o_stage_idx}, {1'h1, 9'h2}, "last stage held");
      i_trig_bus <= 8'h00;
      pulse(4'h2);
    end
  endtask
  task t_step;
    begin
      cfg(2'h2, 2'h3, 1'h1);
      chk({o_mode, o_src}, 4'h8, "source 3 config");
      pulse(4'h1);
      repeat (300) @(posedge i_clk_sys);
      chk({o_running, o_stage_idx}, {1'h1, 9'h0}, "step waits");
      i_ext_trig <= 1'h1;
      repeat (3) @(posedge i_clk_sys);
      chk(o_stage_idx, 0, "unselected source");
      for (k = 1; k < 4; k = k + 1) begin
        pulse(4'h1);
        chk(o_stage_idx, k % 3, "step advance");
      end
      i_ext_trig <= 1'h0;
      pulse(4'h2);
    end
  endtask
  task t_fill;
    begin
      pulse(4'h4);
      chk(o_list_count, 0, "list clear");
      for (k = 0; k < 512; k = k + 1) stage(32'h0100_0000);
      repeat (5) @(posedge i_clk_sys);
      chk({o_list_full, o_list_count}, {1'h1, 10'h200}, "list full");
      for (k = 0; k < 34; k = k + 1) begin
        host.push({1'h0, 32'h1}, ok);
        chk(ok, k < 32, "excess push");
      end
      chk({o_instr_rdy, o_list_count}, {1'h0, 10'h200}, "excess refused");
    end
  endtask
  initial begin
    fail_count = 0;
    samples_checked = 0;
    i_rst_b = 1'h0;
    pl = 4'h0;
    i_cfg_mode = 2'h1;
    i_cfg_src = 2'h0;
    i_cfg_line = 3'h0;
    i_cfg_filt_en = 1'h1;
    i_ext_trig = 1'h0;
    i_trig_bus = 8'h00;
    repeat (16) @(posedge i_clk_sys);
    i_rst_b <= 1'h1;
    @(posedge i_clk_sys);
    chk({o_mode, o_src, o_filt_en, o_running}, 6'h12, "reset config");
    chk({o_instr_rdy, o_list_count}, 11'h400, "reset list");
    host.fill_mem;
    t_cont;
    t_single;
    t_step;
    t_fill;
    stop_test;
  end
endmodule // dss_seq_tb
bind dss_seq dss_seq_chk #(.STAGES(STAGES), .SAW(SAW)) u_chk (.i_clk_sys(i_clk_sys),
  .i_rst_b(i_rst_b), .i_cfg_wr(i_cfg_wr), .i_cfg_src(i_cfg_src), .i_sw_trig(i_sw_trig),
  .i_sw_stop(i_sw_stop), .i_ext_trig(i_ext_trig), .o_running(o_running),
  .o_stage_idx(o_stage_idx), .o_list_count(o_list_count), .o_mode(o_mode),
  .o_src(o_src), .o_filt_en(o_filt_en));
